// *** rtl/dsr_consts.svh ***
// Constants of the digitizer status and readout block
`ifndef DSR_CONSTS_SVH
`define DSR_CONSTS_SVH

// Sample buffer
`define DSR_BUF_DEPTH     10'h100
`define DSR_PTR_W         8

// Block size limits and reset value
`define DSR_BS_MIN        8'h01
`define DSR_BS_MAX        8'h80
`define DSR_BS_RESET      8'h40

// External converter clock limit while the processing clock is internal
`define DSR_EXT_CLK_LIMIT_KHZ 20480

// Measurement state codes
`define DSR_CODE_TRIG     2'h3
`define DSR_CODE_MEAS     2'h2
`define DSR_CODE_ARM      2'h1
`define DSR_CODE_IDLE     2'h0

// Status word bit positions
`define DSR_SB_STATE_LSB  0
`define DSR_SB_PASSED     2
`define DSR_SB_READY      3
`define DSR_SB_ADC_ERR    4
`define DSR_SB_EXT_CLK    5
`define DSR_SB_SETUP_ERR  6
`define DSR_SB_SYNC_CMP   7
`define DSR_SB_READ_VALID 8
`define DSR_SB_MEAS_DONE  9
`define DSR_SB_ARMED      10
`define DSR_SB_OVERFLOW   11
`define DSR_SB_OVERLOAD   12
`define DSR_SB_ERROR      13
`define DSR_SB_MODID_N    14
`define DSR_SB_HW_SET     15

`endif

// *** rtl/dsr_pkg.sv ***
// Types of the digitizer status and readout block
package dsr_pkg;

  typedef enum logic [3:0] {
    DSR_ST_IDLE = 4'h1,
    DSR_ST_ARM  = 4'h2,
    DSR_ST_TRIG = 4'h4,
    DSR_ST_MEAS = 4'h8
  } dsr_state_e;

  typedef enum logic [1:0] {
    DSR_DT_REAL16 = 2'h0,
    DSR_DT_REAL32 = 2'h1,
    DSR_DT_CPLX16 = 2'h2,
    DSR_DT_CPLX32 = 2'h3
  } dsr_dtype_e;

  typedef struct packed {
    dsr_dtype_e  data_type;
    logic        continuous;
    logic        trailer_status_enable;
    logic [15:0] block_size;
  } dsr_cfg_s;

endpackage

// *** rtl/dsr_top.sv ***
// Status word and backplane data readout of a single-channel digitizer
`timescale 1ns/1ps
`include "dsr_consts.svh"

module dsr_top (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  // Measurement control
  input  wire logic             reset_cmd,
  input  wire logic             arm_cmd,
  input  wire logic             force_idle,
  input  wire logic             sync_req,
  input  wire logic             sync_done,
  input  wire logic             pretrig_done,
  input  wire logic             trigger_evt,
  input  wire logic             msg_normal,
  input  wire logic             error_pending,
  input  wire logic             modid_pin,
  input  wire logic             data_port_vme,
  // Configuration
  input  wire logic             cfg_wr,
  input  dsr_pkg::dsr_cfg_s     cfg_req,
  output dsr_pkg::dsr_cfg_s     cfg_active,
  // Converter events
  input  wire logic             adc_fault,
  input  wire logic             adc_overload,
  input  wire logic             ext_clk_fast,
  input  wire logic             dsp_clk_internal,
  // Sample stream
  input  wire logic             in_word_valid,
  input  wire logic [15:0]      in_word,
  // Register reads
  input  wire logic             status_rd,
  input  wire logic             data_rd,
  output logic      [15:0]      rd_data,
  output logic                  rd_valid,
  // Memory self-test
  input  wire logic             memtest_start,
  output logic                  memtest_busy,
  output logic                  memtest_fail,
  output logic                  memtest_done,
  // State view
  output dsr_pkg::dsr_state_e   meas_state
);
  import dsr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Functions
  function automatic logic [2:0] dsr_wmul(input logic [1:0] dt);
    case (dt)
      2'h0:    dsr_wmul = 3'h1;
      2'h3:    dsr_wmul = 3'h4;
      default: dsr_wmul = 3'h2;
    endcase
  endfunction

  function automatic logic [9:0] dsr_words(input logic [1:0] dt, input logic [7:0] bs, input logic app);
    dsr_words = 10'(dsr_wmul(dt)) * 10'(bs) + 10'(app);
  endfunction

  function automatic logic [15:0] dsr_pat(input logic [7:0] a);
    dsr_pat = {a, ~a};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [15:0]             mem [0:255];
  dsr_state_e              state_ff, nxt_state;
  dsr_cfg_s                cfg_ff;
  logic                    modid_s1_ff, modid_s2_ff;
  logic [`DSR_PTR_W-1:0]   wr_ptr_ff, rd_ptr_ff, mt_addr_ff;
  logic [8:0]              cnt_ff;
  logic [9:0]              cap_cnt_ff, out_cnt_ff, need_data;
  logic                    adc_err_ff, ext_clk_ff, setup_err_ff, sync_cmp_ff, blk_done_ff;
  logic                    ovf_ff, ovl_ff, rec_ovl_ff, mt_busy_ff, mt_rd_ff, mt_fail_ff, mt_done_ff;
  logic                    abort_fast, push, full, overflow, trailer_due, pop_word, pop_trailer;
  logic                    meas_done, read_valid, mt_start;
  logic [15:0]             status_word, rd_data_ff;
  logic                    rd_valid_ff;
  logic [7:0]              bs_c;

  assign cfg_active   = cfg_ff;
  assign meas_state   = state_ff;
  assign rd_data      = rd_data_ff;
  assign rd_valid     = rd_valid_ff;
  assign memtest_busy = mt_busy_ff;
  assign memtest_fail = mt_fail_ff;
  assign memtest_done = mt_done_ff;

  // Board select pin synchroniser
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      modid_s1_ff <= 1'b0;
      modid_s2_ff <= 1'b0;
    end else begin
      modid_s1_ff <= modid_pin;
      modid_s2_ff <= modid_s1_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration with block size clamp and fallback
  assign bs_c = (cfg_req.block_size == 16'h0000) ? `DSR_BS_MIN :
                (cfg_req.block_size > 16'(`DSR_BS_MAX)) ? `DSR_BS_MAX : cfg_req.block_size[7:0];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ff       <= '{DSR_DT_REAL16, 1'b0, 1'b0, 16'(`DSR_BS_RESET)};
      setup_err_ff <= 1'b0;
    end else if (reset_cmd) begin
      cfg_ff       <= '{DSR_DT_REAL16, 1'b0, 1'b0, 16'(`DSR_BS_RESET)};
      setup_err_ff <= 1'b0;
    end else if (cfg_wr) begin
      if (dsr_words(cfg_req.data_type, bs_c, cfg_req.trailer_status_enable) <= `DSR_BUF_DEPTH) begin
        cfg_ff       <= '{cfg_req.data_type, cfg_req.continuous, cfg_req.trailer_status_enable, 16'(bs_c)};
        setup_err_ff <= (16'(bs_c) != cfg_req.block_size);
      end else begin
        if (dsr_words(cfg_ff.data_type, bs_c, cfg_ff.trailer_status_enable) <= `DSR_BUF_DEPTH)
          cfg_ff.block_size <= 16'(bs_c);
        cfg_ff.continuous <= cfg_req.continuous;
        setup_err_ff      <= 1'b1;
      end
    end
  end

  assign need_data = dsr_words(cfg_ff.data_type, cfg_ff.block_size[7:0], 1'b0);

  ////////////////////////////////////////////////////////////////////////////////
  // Measurement loop
  assign abort_fast = ext_clk_fast & dsp_clk_internal & (state_ff != DSR_ST_IDLE);
  assign full       = (cnt_ff == 9'(`DSR_BUF_DEPTH));
  assign push       = (state_ff == DSR_ST_MEAS) & in_word_valid & ~mt_busy_ff & ~full &
                      (cfg_ff.continuous | (cap_cnt_ff < need_data));
  assign overflow   = (state_ff == DSR_ST_MEAS) & in_word_valid & full & cfg_ff.continuous;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      DSR_ST_IDLE: begin
        if (arm_cmd && !mt_busy_ff) nxt_state = DSR_ST_ARM;
      end
      DSR_ST_ARM: begin
        if (pretrig_done) nxt_state = DSR_ST_TRIG;
      end
      DSR_ST_TRIG: begin
        if (trigger_evt) nxt_state = DSR_ST_MEAS;
      end
      DSR_ST_MEAS: begin
        if (!cfg_ff.continuous && push && (cap_cnt_ff + 10'h001 >= need_data)) nxt_state = DSR_ST_IDLE;
        if (overflow) nxt_state = DSR_ST_IDLE;
      end
      default: nxt_state = DSR_ST_IDLE;
    endcase
    if (force_idle || abort_fast) nxt_state = DSR_ST_IDLE;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) state_ff <= DSR_ST_IDLE;
    else if (reset_cmd) state_ff <= DSR_ST_IDLE;
    else state_ff <= nxt_state;
  end

  // Block capture count and done flag
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cap_cnt_ff  <= 10'h000;
      blk_done_ff <= 1'b0;
    end else if (reset_cmd || arm_cmd) begin
      cap_cnt_ff  <= 10'h000;
      blk_done_ff <= 1'b0;
    end else begin
      if (state_ff == DSR_ST_TRIG && trigger_evt) cap_cnt_ff <= 10'h000;
      else if (push) cap_cnt_ff <= cap_cnt_ff + 10'h001;
      if (!cfg_ff.continuous && push && (cap_cnt_ff + 10'h001 >= need_data)) blk_done_ff <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sample buffer and backplane data register
  assign trailer_due = cfg_ff.trailer_status_enable & (out_cnt_ff == need_data);
  assign pop_trailer = data_rd & data_port_vme & trailer_due;
  assign pop_word    = data_rd & data_port_vme & ~trailer_due & (cnt_ff != 9'h000) & ~mt_busy_ff;
  assign mt_start    = memtest_start & ~mt_busy_ff & (state_ff == DSR_ST_IDLE);

  always_ff @(posedge sys_clk) begin
    if (mt_busy_ff && !mt_rd_ff) mem[mt_addr_ff] <= dsr_pat(mt_addr_ff);
    else if (push) mem[wr_ptr_ff] <= in_word;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_ff  <= '0;
      rd_ptr_ff  <= '0;
      cnt_ff     <= 9'h000;
      out_cnt_ff <= 10'h000;
    end else if (reset_cmd || mt_start) begin
      wr_ptr_ff  <= '0;
      rd_ptr_ff  <= '0;
      cnt_ff     <= 9'h000;
      out_cnt_ff <= 10'h000;
    end else begin
      if (push) wr_ptr_ff <= wr_ptr_ff + 1'b1;
      if (pop_word) rd_ptr_ff <= rd_ptr_ff + 1'b1;
      cnt_ff <= cnt_ff + 9'(push) - 9'(pop_word);
      if (pop_trailer) out_cnt_ff <= 10'h000;
      else if (pop_word)
        out_cnt_ff <= (out_cnt_ff + 10'h001 == need_data && !cfg_ff.trailer_status_enable) ? 10'h000
                                                                                          : out_cnt_ff + 10'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sticky status flags, set wins over clear
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      adc_err_ff  <= 1'b0;
      ext_clk_ff  <= 1'b0;
      ovl_ff      <= 1'b0;
      sync_cmp_ff <= 1'b0;
      ovf_ff      <= 1'b0;
      rec_ovl_ff  <= 1'b0;
    end else if (reset_cmd) begin
      adc_err_ff  <= 1'b0;
      ext_clk_ff  <= 1'b0;
      ovl_ff      <= 1'b0;
      sync_cmp_ff <= 1'b0;
      ovf_ff      <= 1'b0;
      rec_ovl_ff  <= 1'b0;
    end else begin
      adc_err_ff  <= adc_fault | (adc_err_ff & ~status_rd);
      ext_clk_ff  <= abort_fast | (ext_clk_ff & ~status_rd);
      ovl_ff      <= adc_overload | (ovl_ff & ~status_rd);
      sync_cmp_ff <= sync_done | (sync_cmp_ff & ~(sync_req | force_idle));
      ovf_ff      <= overflow | (ovf_ff & ~arm_cmd);
      rec_ovl_ff  <= (adc_overload & (state_ff == DSR_ST_MEAS)) |
                     (rec_ovl_ff & ~pop_trailer & ~(state_ff == DSR_ST_TRIG && trigger_evt));
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Status word
  assign read_valid = (cnt_ff != 9'h000) | trailer_due;
  assign meas_done  = cfg_ff.continuous ? (10'(cnt_ff) >= need_data) : blk_done_ff;

  always_comb begin
    status_word = 16'h0000;
    case (state_ff)
      DSR_ST_TRIG: status_word[`DSR_SB_STATE_LSB +: 2] = `DSR_CODE_TRIG;
      DSR_ST_MEAS: status_word[`DSR_SB_STATE_LSB +: 2] = `DSR_CODE_MEAS;
      DSR_ST_ARM:  status_word[`DSR_SB_STATE_LSB +: 2] = `DSR_CODE_ARM;
      default:     status_word[`DSR_SB_STATE_LSB +: 2] = `DSR_CODE_IDLE;
    endcase
    status_word[`DSR_SB_PASSED]     = 1'b1;
    status_word[`DSR_SB_READY]      = msg_normal;
    status_word[`DSR_SB_ADC_ERR]    = adc_err_ff;
    status_word[`DSR_SB_EXT_CLK]    = ext_clk_ff;
    status_word[`DSR_SB_SETUP_ERR]  = setup_err_ff;
    status_word[`DSR_SB_SYNC_CMP]   = sync_cmp_ff;
    status_word[`DSR_SB_READ_VALID] = read_valid;
    status_word[`DSR_SB_MEAS_DONE]  = meas_done;
    status_word[`DSR_SB_ARMED]      = (state_ff == DSR_ST_TRIG);
    status_word[`DSR_SB_OVERFLOW]   = ovf_ff;
    status_word[`DSR_SB_OVERLOAD]   = ovl_ff;
    status_word[`DSR_SB_ERROR]      = error_pending;
    status_word[`DSR_SB_MODID_N]    = modid_s2_ff;
    status_word[`DSR_SB_HW_SET]     = ~mt_busy_ff;
  end

  // Read data register; trailer carries the record overload flag
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_ff  <= 16'h0000;
      rd_valid_ff <= 1'b0;
    end else begin
      rd_valid_ff <= status_rd | data_rd;
      if (status_rd) rd_data_ff <= status_word;
      else if (pop_trailer) begin
        rd_data_ff <= status_word;
        rd_data_ff[`DSR_SB_OVERLOAD] <= rec_ovl_ff;
      end else if (pop_word) rd_data_ff <= mem[rd_ptr_ff];
      else if (data_rd) rd_data_ff <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Memory self-test: write pass then check pass
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mt_busy_ff <= 1'b0;
      mt_rd_ff   <= 1'b0;
      mt_addr_ff <= '0;
      mt_fail_ff <= 1'b0;
      mt_done_ff <= 1'b0;
    end else if (reset_cmd) begin
      mt_busy_ff <= 1'b0;
      mt_rd_ff   <= 1'b0;
      mt_addr_ff <= '0;
      mt_done_ff <= 1'b0;
    end else begin
      mt_done_ff <= 1'b0;
      if (mt_start) begin
        mt_busy_ff <= 1'b1;
        mt_rd_ff   <= 1'b0;
        mt_addr_ff <= '0;
        mt_fail_ff <= 1'b0;
      end else if (mt_busy_ff) begin
        mt_addr_ff <= mt_addr_ff + 1'b1;
        if (mt_addr_ff == 8'hFF) mt_rd_ff <= 1'b1;
        if (mt_rd_ff && mem[mt_addr_ff] != dsr_pat(mt_addr_ff)) mt_fail_ff <= 1'b1;
        if (mt_rd_ff && mt_addr_ff == 8'hFF) begin
          mt_busy_ff <= 1'b0;
          mt_done_ff <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking dsr_cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_passed_bit:
    assert property (status_rd |=> rd_data[`DSR_SB_PASSED]) else $error("passed bit not one");
  a_trig_code:
    assert property ((state_ff == DSR_ST_TRIG) |-> status_word[1:0] == 2'h3) else $error("bad trigger code");
  a_adc_err_clear:
    assert property (status_rd && !adc_fault && !reset_cmd |=> !status_word[4]) else $error("adc error not cleared");
  a_adc_err_set:
    assert property (adc_fault && !reset_cmd |=> status_word[4] [*1] ##1 (status_word[4] || $past(status_rd)))
      else $error("adc error lost");
  a_ext_clk_abort:
    assert property (abort_fast && !reset_cmd |=> state_ff == DSR_ST_IDLE && status_word[5]) else $error("no abort");
  a_bs_clamp:
    assert property (cfg_wr && cfg_req.block_size == 16'h0000 && !reset_cmd |=> setup_err_ff)
      else $error("invalid size not flagged");
  a_sync_cmp:
    assert property (sync_done && !reset_cmd |=> status_word[7]) else $error("sync complete missing");
  a_read_valid:
    assert property (push && cnt_ff == 9'h000 && !reset_cmd |=> status_word[8]) else $error("read valid missing");
  a_block_done:
    assert property (!cfg_ff.continuous && push && cap_cnt_ff + 10'h001 == need_data && !reset_cmd && !arm_cmd
      |=> status_word[9] && state_ff == DSR_ST_IDLE) else $error("block done missing");
  a_trailer_ovl:
    assert property (pop_trailer && !status_rd |=> rd_data[12] == $past(rec_ovl_ff)) else $error("trailer flag");
  a_soft_reset:
    assert property (reset_cmd |=> state_ff == DSR_ST_IDLE && cnt_ff == 9'h000 ##1 1'b1)
      else $error("reset incomplete");
  a_memtest_len:
    assert property (mt_start && !reset_cmd |=> mt_busy_ff [*8]) else $error("memtest ended early");
  a_overflow:
    assert property (overflow && !reset_cmd |=> ovf_ff && state_ff == DSR_ST_IDLE) else $error("overflow missed");

  c_block_read: cover property (pop_trailer ##1 rd_valid);
  c_cont_done:  cover property (cfg_ff.continuous && meas_done);
  c_memtest:    cover property (mt_done_ff && !mt_fail_ff);

endmodule

// *** tb/dsr_host.sv ***
// Host model that reads the status word and the backplane data register
`timescale 1ns/1ps

module dsr_host (
  // Clock
  input  wire logic        sys_clk,
  // Register reads
  output logic             status_rd,
  output logic             data_rd,
  output logic             data_port_vme,
  input  wire logic [15:0] rd_data,
  input  wire logic        rd_valid
);

  initial begin
    status_rd = 1'b0;
    data_rd = 1'b0;
    data_port_vme = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One read: strobe up for one edge, answer taken one edge later
  task automatic rd(input logic is_data, output logic [15:0] val, output logic got);
    @(negedge sys_clk);
    if (is_data) begin
      data_rd = 1'b1;
    end else begin
      status_rd = 1'b1;
    end
    @(negedge sys_clk);
    status_rd = 1'b0;
    data_rd = 1'b0;
    val = rd_data;
    got = rd_valid;
  endtask

  // Backplane data port selection, changed at a falling edge
  task automatic port_sel(input logic on);
    data_port_vme = on;
  endtask

  // Reads a whole record so the last word read is the trailer
  task automatic rd_block(input int n, output logic [15:0] rec [0:15], output int miss);
    logic g;
    miss = 0;
    port_sel(1'b1);
    for (int i = 0; i < n && i < 16; i++) begin
      rd(1'b1, rec[i], g);
      if (g !== 1'b1) miss++;
    end
  endtask

endmodule

// *** tb/testbench.sv ***
// Self-checking testbench of the digitizer status and readout block
`timescale 1ns/1ps
`include "dsr_consts.svh"

module testbench;
  import dsr_pkg::*;

  logic        sys_clk, rst_n, reset_cmd, arm_cmd, force_idle, sync_req, sync_done;
  logic        pretrig_done, trigger_evt, msg_normal, error_pending, modid_pin, cfg_wr;
  logic        adc_fault, adc_overload, ext_clk_fast, dsp_clk_internal, in_word_valid;
  logic        status_rd, data_rd, data_port_vme, rd_valid, memtest_start;
  logic        memtest_busy, memtest_fail, memtest_done;
  logic [15:0] in_word, rd_data;
  dsr_cfg_s    cfg_req, cfg_active;
  dsr_state_e  meas_state;
  int          num_errors, checked;

  dsr_top uut (
    .sys_clk(sys_clk), .rst_n(rst_n), .reset_cmd(reset_cmd), .arm_cmd(arm_cmd),
    .force_idle(force_idle), .sync_req(sync_req), .sync_done(sync_done),
    .pretrig_done(pretrig_done), .trigger_evt(trigger_evt), .msg_normal(msg_normal),
    .error_pending(error_pending), .modid_pin(modid_pin), .data_port_vme(data_port_vme),
    .cfg_wr(cfg_wr), .cfg_req(cfg_req), .cfg_active(cfg_active), .adc_fault(adc_fault),
    .adc_overload(adc_overload), .ext_clk_fast(ext_clk_fast), .dsp_clk_internal(dsp_clk_internal),
    .in_word_valid(in_word_valid), .in_word(in_word), .status_rd(status_rd), .data_rd(data_rd),
    .rd_data(rd_data), .rd_valid(rd_valid), .memtest_start(memtest_start),
    .memtest_busy(memtest_busy), .memtest_fail(memtest_fail), .memtest_done(memtest_done),
    .meas_state(meas_state)
  );

  dsr_host host (
    .sys_clk(sys_clk), .status_rd(status_rd), .data_rd(data_rd),
    .data_port_vme(data_port_vme), .rd_data(rd_data), .rd_valid(rd_valid)
  );

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (num_errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  task automatic pulse(ref logic s);
    @(negedge sys_clk);
    s = 1'b1;
    @(negedge sys_clk);
    s = 1'b0;
  endtask

  task automatic rs(input logic [15:0] mask, input logic [15:0] exp);
    logic [15:0] v;
    logic        g;
    host.rd(1'b0, v, g);
    chk({15'h0000, g}, 16'h0001, "status answer");
    chk(v & mask, exp, "status bits");
  endtask

  task automatic st(input dsr_state_e e);
    chk({12'h000, meas_state}, {12'h000, e}, "state");
  endtask

  task automatic cfg(input dsr_dtype_e dt, input logic cont, input logic tr, input logic [15:0] bs);
    cfg_req = '{data_type: dt, continuous: cont, trailer_status_enable: tr, block_size: bs};
    pulse(cfg_wr);
  endtask

  task automatic feed(input int n, input int ovl);
    for (int i = 0; i < n; i++) begin
      @(negedge sys_clk);
      in_word_valid = 1'b1;
      in_word = 16'hA000 + 16'(i);
      adc_overload = (i == ovl);
    end
    @(negedge sys_clk);
    in_word_valid = 1'b0;
    adc_overload = 1'b0;
    @(negedge sys_clk);
  endtask

  task automatic start_meas();
    pulse(arm_cmd);
    rs(16'h0003, {14'h0000, `DSR_CODE_ARM});
    pulse(pretrig_done);
    rs(16'h0003, {14'h0000, `DSR_CODE_TRIG});
    pulse(trigger_evt);
    rs(16'h0003, {14'h0000, `DSR_CODE_MEAS});
    st(DSR_ST_MEAS);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_flags();
    msg_normal = 1'b1;
    rs(16'h0008, 16'h0008);
    msg_normal = 1'b0;
    pulse(adc_fault);
    rs(16'h0010, 16'h0010);
    rs(16'h0010, 16'h0000);
    pulse(sync_req);
    rs(16'h0080, 16'h0000);
    pulse(sync_done);
    rs(16'h0080, 16'h0080);
    pulse(force_idle);
    rs(16'h0080, 16'h0000);
    pulse(sync_done);
    rs(16'h0080, 16'h0080);
  endtask

  task automatic t_cfg();
    cfg(DSR_DT_REAL16, 1'b0, 1'b0, 16'h0000);
    chk(cfg_active.block_size, 16'h0001, "size floor");
    rs(16'h0040, 16'h0040);
    cfg(DSR_DT_REAL16, 1'b0, 1'b0, 16'h00C8);
    chk(cfg_active.block_size, 16'h0080, "size ceiling");
    cfg(DSR_DT_REAL16, 1'b0, 1'b0, 16'h0010);
    rs(16'h0040, 16'h0000);
    cfg(DSR_DT_CPLX32, 1'b0, 1'b1, 16'h0040);
    chk({14'h0000, cfg_active.data_type}, 16'h0000, "type kept");
    chk({15'h0000, cfg_active.trailer_status_enable}, 16'h0000, "trailer kept");
    chk(cfg_active.block_size, 16'h0040, "size applied");
    rs(16'h0040, 16'h0040);
  endtask

  task automatic t_abort();
    dsp_clk_internal = 1'b1;
    ext_clk_fast = 1'b1;
    repeat (2) @(negedge sys_clk);
    rs(16'h0020, 16'h0000);
    ext_clk_fast = 1'b0;
    cfg(DSR_DT_REAL16, 1'b0, 1'b0, 16'h0004);
    start_meas();
    ext_clk_fast = 1'b1;
    repeat (2) @(negedge sys_clk);
    ext_clk_fast = 1'b0;
    st(DSR_ST_IDLE);
    rs(16'h0020, 16'h0020);
    rs(16'h0020, 16'h0000);
  endtask

  task automatic t_block();
    logic [15:0] rec [0:15];
    int          w, miss;
    logic        g;
    for (int d = 0; d < 4; d++) begin
      w = (d == 0) ? 1 : ((d == 3) ? 4 : 2);
      cfg(dsr_dtype_e'(d), 1'b0, 1'b1, 16'h0002);
      start_meas();
      feed(2 * w, (d == 1) ? 0 : 99);
      st(DSR_ST_IDLE);
      rs(16'h0300, 16'h0300);
      if (d == 0) begin
        // A data read with the port deselected must pop nothing
        host.port_sel(1'b0);
        host.rd(1'b1, rec[0], g);
        chk(rec[0], 16'h0000, "read with port off");
        chk({15'h0000, g}, 16'h0001, "answer with port off");
      end
      host.rd_block(2 * w + 1, rec, miss);
      chk(16'(miss), 16'h0000, "data answers");
      for (int i = 0; i < 2 * w; i++) chk(rec[i], 16'hA000 + 16'(i), "sample");
      chk({15'h0000, rec[2 * w][`DSR_SB_OVERLOAD]}, {15'h0000, d == 1}, "trailer overload");
      rs(16'h0100, 16'h0000);
    end
  endtask

  task automatic t_cont();
    cfg(DSR_DT_REAL16, 1'b1, 1'b0, 16'h0002);
    start_meas();
    feed(1, 999);
    rs(16'h0200, 16'h0000);
    feed(1, 999);
    rs(16'h0300, 16'h0300);
    feed(255, 999);
    st(DSR_ST_IDLE);
    rs(16'h0800, 16'h0800);
    pulse(reset_cmd);
    st(DSR_ST_IDLE);
    rs(16'h0B03, 16'h0000);
    chk(cfg_active.block_size, 16'h0040, "size after reset");
  endtask

  task automatic t_mem();
    pulse(memtest_start);
    rs(16'h8000, 16'h0000);
    for (int i = 0; i < 600 && memtest_done !== 1'b1; i++) @(negedge sys_clk);
    chk({13'h0000, memtest_busy, memtest_done, memtest_fail}, 16'h0002, "memory test");
    rs(16'h8000, 16'h8000);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, reset_cmd, arm_cmd, force_idle, sync_req, sync_done, pretrig_done} = 7'h00;
    {trigger_evt, msg_normal, error_pending, modid_pin, cfg_wr, adc_fault} = 6'h00;
    {adc_overload, ext_clk_fast, dsp_clk_internal, in_word_valid, memtest_start} = 5'h00;
    in_word = 16'h0000;
    cfg_req = '0;
    num_errors = 0;
    checked = 0;
    repeat (20) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_n = 1'b1;
    rs(16'h8F7F, 16'h8004);
    chk(cfg_active.block_size, 16'h0040, "size at reset");
    t_flags();
    t_cfg();
    t_abort();
    t_block();
    t_cont();
    t_mem();
    summarize();
  end

  // Run needs about a thousand cycles; give up after 20000
  initial begin
    #1000000;
    num_errors++;
    summarize();
  end

endmodule
